/* File: hdl/dsm_edge_meter.v */
// Edge counter over a fixed gate, one per input signal
`timescale 1ns/1ps
`default_nettype none
`include "dsm_regs.vh"
module dsm_edge_meter (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_ce,
  // Gate and signal
  input wire i_gate,
  input wire i_sig,
  // Result
  output reg [`DSM_CW-1:0] o_count
);
  reg prev;
  reg armed;
  reg [`DSM_CW-1:0] acc;
  wire rise;
  // No edge until a real previous level is held, so a pin that is
  // already high when reset ends is not counted as a phantom edge
  assign rise = i_sig & ~prev & armed;

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev <= 1'b0;
      armed <= 1'b0;
      acc <= `DSM_CNT_RST;
      o_count <= `DSM_FREQ_RST;
    end else if (i_ce) begin
      prev <= i_sig;
      armed <= 1'b1;
      if (i_gate) begin
        // Count of this cycle's edge is carried into the next gate
        o_count <= acc;
        acc <= rise ? 16'h0001 : `DSM_CNT_RST;
      end else if (rise && acc != 16'hFFFF) begin
        acc <= acc + 16'h0001;
      end
    end
  end
endmodule // dsm_edge_meter
`default_nettype wire

/* File: hdl/dsm_regs.vh */
// Constants for the dual axis speed monitor
`ifndef DSM_REGS_VH
`define DSM_REGS_VH
// Clock rate and measurement gate of 2500 cycles (0.1 ms)
`define DSM_CLK_HZ 25000000
`define DSM_GATE_CYC 24'h00_09C4
// Short gate trades frequency resolution for a fast reaction time
`define DSM_GATES_PER_S 10000
// Fixed fault floor of 2 Hz, as an edge count per gate (rounded up)
`define DSM_FLOOR_HZ 2
`define DSM_FLOOR_CNT 16'h0001
// Counter width
`define DSM_CW 16
// Input configuration codes
`define DSM_CFG_ENC 2'h0
`define DSM_CFG_PROX 2'h1
`define DSM_CFG_BOTH 2'h2
// Direction mismatch behaviour codes
`define DSM_DIR_AXIS 1'b0
`define DSM_DIR_STOP 1'b1
// Reset values
`define DSM_CNT_RST 16'h0000
`define DSM_FREQ_RST 16'h0000
`endif

/* File: hdl/dsm_speed_monitor.v */
// Dual axis speed and standstill monitor core
// Behaviour
// - Each axis evaluated separately, own outputs
// - Report every axis status to base
// - Single channel fault forces axis safe
// - Overspeed output low means safe
// - Channel frequency mismatch above limits: safe
// - Direction mismatch: axis safe, auto release
// - Encoder plus proximity: three signals used
// - Standstill when two of three slow
// - Shearpin: tracks slow, proximity fast
// - Shearpin break forces safe, auto release
// - Eight selectable speed thresholds per axis
`timescale 1ns/1ps
`default_nettype none
`include "dsm_regs.vh"
module dsm_speed_monitor (
  // Clock, reset, enable
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_ce,
  // Axis 1 inputs: encoder tracks and proximity switches
  input wire i_axis1_enc_a,
  input wire i_axis1_enc_b,
  input wire i_axis1_prox_in_a,
  input wire i_axis1_prox_in_b,
  // Axis 2 inputs
  input wire i_axis2_enc_a,
  input wire i_axis2_enc_b,
  input wire i_axis2_prox_in_a,
  input wire i_axis2_prox_in_b,
  // Per-axis channel fault detectors (open circuit)
  input wire [1:0] i_chan_fault,
  // Configuration, index 0 is axis 1
  input wire [3:0] i_input_cfg,
  input wire [1:0] i_shearpin_en,
  input wire i_dir_mode,
  input wire [31:0] i_standstill_cnt,
  input wire [5:0] i_speed_sel,
  input wire [255:0] i_speed_table,
  // Status to base controller
  output reg [1:0] o_standstill,
  output reg [1:0] o_overspeed_ok,
  output reg [1:0] o_dir_fwd,
  output reg [1:0] o_axis_ok,
  output reg [1:0] o_shearpin_break,
  output reg [1:0] o_freq_fault,
  output reg [1:0] o_dir_fault,
  output reg o_system_stop
);
  ////////////////////////////////////////////////////////////////////////
  // Measurement gate
  localparam [23:0] GATE_LAST = `DSM_GATE_CYC - 24'h00_0001;
  reg [23:0] gate_cnt;
  reg gate;
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gate_cnt <= 24'h00_0000;
      gate <= 1'b0;
    end else if (i_ce) begin
      gate <= (gate_cnt == GATE_LAST);
      gate_cnt <= (gate_cnt == GATE_LAST) ? 24'h00_0000 : gate_cnt + 24'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Edge meters, four per axis
  wire [7:0] sig_in;
  wire [`DSM_CW-1:0] freq [0:7];
  assign sig_in = {i_axis2_prox_in_b, i_axis2_prox_in_a, i_axis2_enc_b,
                   i_axis2_enc_a, i_axis1_prox_in_b, i_axis1_prox_in_a,
                   i_axis1_enc_b, i_axis1_enc_a};
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_meter
      dsm_edge_meter u_meter (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_gate(gate),
        .i_sig(sig_in[g]),
        .o_count(freq[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Quadrature direction per axis: A leading B means forward
  reg [1:0] a_prev;
  reg [1:0] fwd_seen;
  reg [1:0] rev_seen;
  reg [1:0] dir_fwd;
  integer k;
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      a_prev <= 2'h0;
      fwd_seen <= 2'h0;
      rev_seen <= 2'h0;
      dir_fwd <= 2'h0;
    end else if (i_ce) begin
      for (k = 0; k < 2; k = k + 1) begin
        a_prev[k] <= sig_in[4*k];
        if (gate) begin
          // Decision per gate; a gate with both senses is a mismatch
          dir_fwd[k] <= fwd_seen[k] & ~rev_seen[k];
          fwd_seen[k] <= 1'b0;
          rev_seen[k] <= 1'b0;
        end else if (sig_in[4*k] & ~a_prev[k]) begin
          if (!sig_in[4*k+1])
            fwd_seen[k] <= 1'b1;
          else
            rev_seen[k] <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-axis evaluation
  reg [1:0] next_standstill;
  reg [1:0] next_overspeed_ok;
  reg [1:0] next_axis_ok;
  reg [1:0] next_shear;
  reg [1:0] next_ffault;
  reg [1:0] next_dfault;
  reg [1:0] dir_mix;
  reg [`DSM_CW-1:0] fa, fb, fp, fq, ss, lim, fmax;
  reg sa, sb, sp, sq;
  reg [1:0] cfg;
  reg [2:0] sel;
  integer j;
  always @* begin
    next_standstill = 2'h0;
    next_overspeed_ok = 2'h0;
    next_axis_ok = 2'h0;
    next_shear = 2'h0;
    next_ffault = 2'h0;
    next_dfault = 2'h0;
    dir_mix = 2'h0;
    fa = 16'h0000; fb = 16'h0000; fp = 16'h0000; fq = 16'h0000;
    ss = 16'h0000; lim = 16'h0000; fmax = 16'h0000;
    sa = 1'b0; sb = 1'b0; sp = 1'b0; sq = 1'b0;
    cfg = 2'h0;
    sel = 3'h0;
    for (j = 0; j < 2; j = j + 1) begin
      fa = freq[4*j];
      fb = freq[4*j+1];
      fp = freq[4*j+2];
      fq = freq[4*j+3];
      ss = i_standstill_cnt[16*j +: 16];
      cfg = i_input_cfg[2*j +: 2];
      sel = i_speed_sel[3*j +: 3];
      lim = i_speed_table[128*j + 16*sel +: 16];
      sa = (fa <= ss);
      sb = (fb <= ss);
      sp = (fp <= ss);
      sq = (fq <= ss);
      fmax = 16'h0000;
      case (cfg)
        `DSM_CFG_ENC: begin
          next_standstill[j] = sa & sb;
          fmax = (fa > fb) ? fa : fb;
          if (fa != fb) next_ffault[j] = 1'b1;
        end
        `DSM_CFG_PROX: begin
          next_standstill[j] = sp & sq;
          fmax = (fp > fq) ? fp : fq;
          if (fp != fq) next_ffault[j] = 1'b1;
        end
        `DSM_CFG_BOTH: begin
          // Proximity B is unused here
          next_standstill[j] = (sa & sb) | (sa & sp) | (sb & sp);
          fmax = (fa > fb) ? fa : fb;
          if (fp > fmax) fmax = fp;
          if (fa != fb) next_ffault[j] = 1'b1;
          if (i_shearpin_en[j] && sa && sb && !sp)
            next_shear[j] = 1'b1;
        end
        default: begin
          next_ffault[j] = 1'b1;
        end
      endcase
      // Mismatch only counts above standstill and the 2 Hz floor
      if (!(fmax > ss && fmax >= `DSM_FLOOR_CNT))
        next_ffault[j] = (cfg == 2'h3);
      if (cfg != `DSM_CFG_PROX && fwd_seen[j] && rev_seen[j])
        dir_mix[j] = 1'b1;
      next_dfault[j] = dir_mix[j];
      next_axis_ok[j] = !i_chan_fault[j] && !next_ffault[j] &&
                        !next_shear[j] && !next_dfault[j];
      next_overspeed_ok[j] = next_axis_ok[j] && (fmax <= lim);
      // A faulted axis never claims standstill
      next_standstill[j] = next_standstill[j] & next_axis_ok[j];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // The first gate end only holds reset counts, not a measurement;
  // reporting them would claim standstill before anything was seen
  reg primed;
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n)
      primed <= 1'b0;
    else if (i_ce && gate)
      primed <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Status registers, updated each gate after the first
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_standstill <= 2'h0;
      o_overspeed_ok <= 2'h0;
      o_dir_fwd <= 2'h0;
      o_axis_ok <= 2'h0;
      o_shearpin_break <= 2'h0;
      o_freq_fault <= 2'h0;
      o_dir_fault <= 2'h0;
      o_system_stop <= 1'b0;
    end else if (i_ce && gate && primed) begin
      // Axis safe states clear on the next clean gate; only o_system_stop latches
      o_standstill <= next_standstill;
      o_overspeed_ok <= next_overspeed_ok;
      o_dir_fwd <= dir_fwd;
      o_axis_ok <= next_axis_ok;
      o_shearpin_break <= next_shear;
      o_freq_fault <= next_ffault;
      o_dir_fault <= next_dfault;
      // Legacy mode stops the whole system and stays stopped
      if (i_dir_mode == `DSM_DIR_STOP && |next_dfault)
        o_system_stop <= 1'b1;
    end
  end
endmodule // dsm_speed_monitor
`default_nettype wire

/* File: testbench/dsm_base_model.sv */
// Base controller model that routes axis status to relays
`timescale 1ns/1ps
`default_nettype none
module dsm_base_model (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Status from the monitor
  input wire logic [1:0] i_axis_ok,
  input wire logic [1:0] i_overspeed_ok,
  // Routed relays, high means release
  output logic [1:0] o_relay
);
  // Relay drops on either safe indication
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) o_relay <= 2'h0;
    else o_relay <= i_axis_ok & i_overspeed_ok;
  end
endmodule // dsm_base_model
`default_nettype wire

/* File: testbench/dsm_speed_monitor_monitor.sv */
// Concurrent checks on the speed monitor ports
`timescale 1ns/1ps
`default_nettype none
module dsm_speed_monitor_monitor (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst_n,
  // Watched ports
  input wire [1:0] i_chan_fault,
  input wire [1:0] o_axis_ok,
  input wire [1:0] o_standstill,
  input wire [1:0] o_overspeed_ok,
  input wire [1:0] o_freq_fault,
  input wire [1:0] o_shearpin_break,
  input wire [1:0] o_dir_fault,
  input wire o_system_stop
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////////////////////
  AST_OVS0: assert property (!o_axis_ok[0] |-> !o_overspeed_ok[0])
    else $error("overspeed ok on faulted axis 1");
  AST_OVS1: assert property (!o_axis_ok[1] |-> !o_overspeed_ok[1])
    else $error("overspeed ok on faulted axis 2");
  AST_FREQ: assert property ((o_freq_fault & o_axis_ok) == 2'h0)
    else $error("axis ok during frequency fault");
  AST_SHEAR: assert property (
    (o_shearpin_break & o_axis_ok) == 2'h0)
    else $error("axis ok during shearpin break");
  AST_STILL: assert property ((o_standstill & ~o_axis_ok) == 2'h0)
    else $error("standstill reported on faulted axis");
  AST_DIR: assert property ((o_dir_fault & o_axis_ok) == 2'h0)
    else $error("axis ok during direction fault");
  AST_STOP: assert property (o_system_stop |=> o_system_stop)
    else $error("system stop released");
  // Results change only at a gate end, never twice in a row
  AST_HOLD: assert property (
    !$stable(o_axis_ok) |=> $stable(o_axis_ok)[*8])
    else $error("axis status not held");
  // The release edge uses the fault input sampled one clock earlier
  AST_CHAN: assert property ($rose(o_axis_ok[0]) |->
    !$past(i_chan_fault[0]))
    else $error("axis 1 released under channel fault");
endmodule // dsm_speed_monitor_monitor
bind dsm_speed_monitor dsm_speed_monitor_monitor u_dsm_speed_monitor_monitor (
  .i_mclk, .i_rst_n, .i_chan_fault, .o_axis_ok, .o_standstill, .o_overspeed_ok,
  .o_freq_fault, .o_shearpin_break, .o_dir_fault, .o_system_stop);
`default_nettype wire

/* File: testbench/dsm_speed_monitor_tb.sv */
// Self-checking bench for the dual axis speed monitor
`timescale 1ns/1ps
`default_nettype none
module dsm_speed_monitor_tb;
  localparam int G = 2500;
  localparam int P = 250;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [3:0] cfg = 4'h0;
  logic [3:0] run = 4'h0;
  logic [1:0] cf = 2'h0;
  logic [1:0] shp = 2'h0;
  logic dm = 1'b0;
  logic [5:0] sel = 6'h00;
  logic [31:0] ph = 32'h0000_0000;
  logic [1:0] ss, ovs, fwd, aok, shb, ffl, dfl, rly;
  logic stp;
  int n_mismatch = 0;
  int num_checks = 0;
  // Ten rising edges per gate; track b lags a by a quarter turn
  wire a = (ph % P) < P / 2;
  wire b = ((ph + P - P / 4) % P) < P / 2;
  // Axis 2 encoder swaps its tracks each half gate: both senses per gate
  wire w = (ph % G) < G / 2;
  always #20 i_mclk = ~i_mclk;
  always @(posedge i_mclk) ph <= ph + 1;
  ////////////////////////////////////////////////////////////////////////////
  dsm_speed_monitor u_dsm_speed_monitor (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(1'b1),
    .i_axis1_enc_a(run[0] & a), .i_axis1_enc_b(run[0] & b),
    .i_axis1_prox_in_a(run[3] & a), .i_axis1_prox_in_b(1'b0),
    .i_axis2_enc_a(run[2] & (w ? a : b)),
    .i_axis2_enc_b(run[2] & (w ? b : a)),
    .i_axis2_prox_in_a(run[1] & a), .i_axis2_prox_in_b(run[2] & a),
    .i_chan_fault(cf), .i_input_cfg(cfg), .i_shearpin_en(shp),
    .i_dir_mode(dm), .i_standstill_cnt(32'h0002_0002),
    .i_speed_sel(sel),
    .i_speed_table({96'h0, 32'h0005_0014, 96'h0, 32'h0005_0014}),
    .o_standstill(ss), .o_overspeed_ok(ovs), .o_dir_fwd(fwd),
    .o_axis_ok(aok), .o_shearpin_break(shb), .o_freq_fault(ffl),
    .o_dir_fault(dfl), .o_system_stop(stp));
  dsm_base_model u_dsm_base_model (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_axis_ok(aok),
    .i_overspeed_ok(ovs), .o_relay(rly));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Three gate ends: partial gate, full gate, then its report
  task automatic apply(input logic [3:0] c, input logic [3:0] r,
                       input logic [1:0] f, input logic [1:0] s,
                       input logic [5:0] l);
    @(posedge i_mclk);
    cfg <= c;
    run <= r;
    cf <= f;
    shp <= s;
    sel <= l;
    repeat (3 * G + 20) @(posedge i_mclk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(posedge i_mclk);
    #1;
    chk(aok | ovs, 2'b00);
    apply(4'h4, 4'b0011, 2'b00, 2'b00, 6'h00);
    chk({aok[0], ovs[0]}, 2'b11);
    chk({fwd[0], ss[0]}, 2'b10);
    chk({ffl[1], aok[1]}, 2'b10);
    chk(rly, 2'b01);
    apply(4'h8, 4'b0011, 2'b01, 2'b10, 6'h01);
    chk({aok[0], ovs[0]}, 2'b00);
    chk({shb[1], aok[1]}, 2'b10);
    apply(4'h2, 4'b1001, 2'b00, 2'b00, 6'h01);
    chk({ovs[0], ss[0]}, 2'b00);
    chk({aok[1], ss[1]}, 2'b11);
    chk(shb | ffl, 2'b00);
    chk({stp, dfl[0]}, 2'b00);
    apply(4'h2, 4'b1100, 2'b00, 2'b00, 6'h00);
    chk({ss[0], aok[0]}, 2'b11);
    chk({dfl[1], aok[1]}, 2'b10);
    chk({stp, ovs[0]}, 2'b01);
    apply(4'h2, 4'b1000, 2'b00, 2'b00, 6'h00);
    chk({dfl[1], aok[1]}, 2'b01);
    chk({stp, rly[1]}, 2'b01);
    @(posedge i_mclk);
    dm <= 1'b1;
    apply(4'h2, 4'b1100, 2'b00, 2'b00, 6'h00);
    chk({stp, dfl[1]}, 2'b11);
    give_verdict();
  end
  initial begin
    repeat (20 * G) @(posedge i_mclk);
    n_mismatch++;
    give_verdict();
  end
endmodule // dsm_speed_monitor_tb
`default_nettype wire
